// file: verilog/adcop_map.vh
/*
 * constants for the converter output port: strap decode, code limits,
 * recovery counts and the one-hot state codes.
 * assumes inclusion by bare name from the design file.
 */
`ifndef ADCOP_MAP_VH
`define ADCOP_MAP_VH

// four strap levels, already digitised to two bits outside this block
`define ADCOP_STRAP_GND 2'h0
`define ADCOP_STRAP_THIRD 2'h1
`define ADCOP_STRAP_TWO_THIRD 2'h2
`define ADCOP_STRAP_VDD 2'h3

// 12-bit word limits, offset binary
`define ADCOP_CODE_MAX 12'hfff
`define ADCOP_CODE_MIN 12'h000

// encode cycles before valid output after nap, and stabilizer relock
`define ADCOP_NAP_CYCLES 100
`define ADCOP_RELOCK_CYCLES 100
// encode-clock silence (mclk cycles) that counts as a long stop
`define ADCOP_STOP_MCLK 64

// interrupt status layout
`define ADCOP_EV_OVF 0
`define ADCOP_EV_SLEEP_EXIT 1
`define ADCOP_EV_NAP_EXIT 2
`define ADCOP_EV_WIDTH 3

// register byte offsets on the avalon slave
`define ADCOP_REG_STATUS 4'h0
`define ADCOP_REG_CLEAR 4'h4
`define ADCOP_REG_ENABLE 4'h8
`define ADCOP_REG_STATE 4'hc

// one-hot power states
`define ADCOP_ST_RUN 4'h1
`define ADCOP_ST_NAP 4'h2
`define ADCOP_ST_SLEEP 4'h4
`define ADCOP_ST_WAKE 4'h8

`endif

// file: verilog/adcop_port.v
/*
 * output port of a 12-bit sampling converter: takes each conversion
 * result on the encode clock, codes it, drives word, overflow flag and
 * a delayed encode clock, with disable and power-down pins.
 * assumes conversions arrive on mclk as raw value plus range flags; the
 * encode clock is a pin sampled by mclk (it must be well below mclk/2).
 */
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps

// the constants must be known before the parameter list uses them
`include "adcop_map.vh"

module adcop_port #(
    parameter WIDTH = 12,
    parameter NAP_CYCLES = `ADCOP_NAP_CYCLES,
    parameter SLEEP_CYCLES = 100000
) (
    // clock and reset
    input wire mclk,
    input wire resetn,
    // pins from outside the mclk domain
    input wire encode_clock_pos,
    input wire [1:0] format_strap,
    input wire output_disable,
    input wire power_down_pin,
    // conversion result from the core, on mclk
    input wire [WIDTH-1:0] conv_value,
    input wire conv_over,
    input wire conv_under,
    // output pins with enables
    output reg [WIDTH-1:0] sample_word,
    output reg [WIDTH-1:0] sample_word_oe,
    output reg overflow_flag,
    output reg overflow_flag_oe,
    output reg sample_clock_out,
    output reg sample_clock_out_oe,
    output reg stabilizer_on,
    output reg data_valid,
    // avalon-mm slave
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg irq
);

    // strap levels and what they select:
    //   ground      -> offset binary, stabilizer off
    //   one third   -> offset binary, stabilizer on
    //   two thirds  -> two's complement, stabilizer on
    //   full supply -> two's complement, stabilizer off
    // the format follows the upper strap bit and the stabilizer follows
    // the middle pair; each is decoded in one place, in a function of its
    // own, called once, at the word for format and at dcs_want for the stabilizer.
    // a strap is meant to be tied, not toggled: a change while running
    // takes effect at the next encode rise (for the stabilizer, at the next mclk edge) after it has crossed the
    // synchroniser, and one word may carry the old format.

    // strap decode, one function for format and one for stabilizer
    function strap_twos;
        input [1:0] s;
        begin
            strap_twos = (s == `ADCOP_STRAP_TWO_THIRD) || (s == `ADCOP_STRAP_VDD);
        end
    endfunction

    function strap_dcs;
        input [1:0] s;
        begin
            strap_dcs = (s == `ADCOP_STRAP_THIRD) || (s == `ADCOP_STRAP_TWO_THIRD);
        end
    endfunction

    // every pin is asynchronous to mclk. the first stage may go
    // metastable, so only the second stage reads it; the agree test
    // between stages two and three filters a single-cycle glitch.
    // the price is latency: a pin edge reaches pin_q four to five mclk
    // edges later; as the agree test needs each level held two mclk cycles, the encode rate must stay under mclk/4.
    // the two strap bits are synchronised separately; a strap that is
    // tied never moves, so skew between them does not matter.
    // three-stage synchronisers for the five pin inputs
    localparam NPIN = 5;
    wire [NPIN-1:0] pin_raw;
    reg [NPIN-1:0] s1_q;
    reg [NPIN-1:0] s2_q;
    reg [NPIN-1:0] s3_q;
    reg [NPIN-1:0] pin_q;
    assign pin_raw = {power_down_pin, output_disable, format_strap, encode_clock_pos};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
            // a change counts once the second and third stages agree
            always @(posedge mclk) begin
                if (!resetn) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    pin_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= pin_raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        pin_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate

    wire enc_s = pin_q[0];
    wire [1:0] strap_s = pin_q[2:1];
    wire dis_s = pin_q[3];
    wire pd_s = pin_q[4];

    // encode edge detection
    reg enc_prev_q;
    wire enc_rise = enc_s & ~enc_prev_q;
    wire enc_fall = ~enc_s & enc_prev_q;

    // power state machine, one-hot
    //   run:   normal conversion, outputs follow the disable pin
    //   nap:   reference kept, outputs floating
    //   sleep: everything off, outputs floating
    //   wake:  outputs back, data held invalid while the count runs
    // nap and sleep may swap while power-down stays high, since the
    // disable pin alone tells them apart. the wake count is in encode
    // cycles, not mclk cycles, because recovery follows the encode clock.
    // sleep recovery is parameterised: the real figure is milliseconds
    // and a bench would never reach it at its default.
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [16:0] wake_cnt_q;
    reg [16:0] wake_cnt_d;
    reg woke_from_sleep_q;
    reg [6:0] stop_cnt_q;
    reg [6:0] relock_cnt_q;
    localparam [16:0] NAP_CNT = NAP_CYCLES;
    localparam [16:0] SLEEP_CNT = SLEEP_CYCLES;
    localparam [6:0] STOP_LIM = `ADCOP_STOP_MCLK;
    localparam [6:0] RELOCK_LIM = `ADCOP_RELOCK_CYCLES;

    wire powered = state_q[0] | state_q[3];

    always @* begin
        state_d = state_q;
        wake_cnt_d = wake_cnt_q;
        case (state_q)
            `ADCOP_ST_RUN: begin
                if (pd_s) begin
                    state_d = dis_s ? `ADCOP_ST_SLEEP : `ADCOP_ST_NAP;
                end
            end
            `ADCOP_ST_NAP, `ADCOP_ST_SLEEP: begin
                if (!pd_s) begin
                    state_d = `ADCOP_ST_WAKE;
                    // sleep recovery is far longer: the reference restarts
                    wake_cnt_d = state_q[2] ? SLEEP_CNT : NAP_CNT;
                end else if (state_q[1] && dis_s) begin
                    state_d = `ADCOP_ST_SLEEP;
                end else if (state_q[2] && !dis_s) begin
                    state_d = `ADCOP_ST_NAP;
                end
            end
            `ADCOP_ST_WAKE: begin
                if (pd_s) begin
                    state_d = dis_s ? `ADCOP_ST_SLEEP : `ADCOP_ST_NAP;
                end else if (wake_cnt_q == 17'h00000) begin
                    state_d = `ADCOP_ST_RUN;
                end else if (enc_rise) begin
                    wake_cnt_d = wake_cnt_q - 17'h00001; // counts encode cycles
                end
            end
            default: begin
                state_d = `ADCOP_ST_RUN;
            end
        endcase
    end

    // encode clock stop detection and stabilizer relock
    wire dcs_want = strap_dcs(strap_s);
    wire locked = (relock_cnt_q == 7'h00);

    // coded word: clamp out-of-range, then invert msb for two's complement
    // the clamp comes first so that the two formats agree on which code
    // an out-of-range input gives; the flag is carried beside the word.
    reg [WIDTH-1:0] code_d;
    always @* begin
        if (conv_over) begin
            code_d = `ADCOP_CODE_MAX;
        end else if (conv_under) begin
            code_d = `ADCOP_CODE_MIN;
        end else begin
            code_d = conv_value;
        end
        if (strap_twos(strap_s)) begin
            code_d[WIDTH-1] = ~code_d[WIDTH-1];
        end
        // offset binary passes unchanged
    end

    // interrupt events
    // overflow is caught on the encode rise that samples the result, so
    // one out-of-range sample is enough to set it. the two exit events
    // fire once, on the cycle the wake count ends, and tell software
    // whether the reference had to restart. an event and a clear in the
    // same cycle leave the bit set, so no event is ever lost.
    reg [`ADCOP_EV_WIDTH-1:0] ev_stat_q;
    reg [`ADCOP_EV_WIDTH-1:0] ev_en_q;
    wire [`ADCOP_EV_WIDTH-1:0] ev_set;
    wire do_wr = avs_write & ~avs_waitrequest;
    wire do_rd = avs_read & ~avs_waitrequest;
    wire [`ADCOP_EV_WIDTH-1:0] ev_clr =
        (do_wr && avs_address == `ADCOP_REG_CLEAR) ? avs_writedata[`ADCOP_EV_WIDTH-1:0] : {`ADCOP_EV_WIDTH{1'b0}};
    wire wake_done = state_q[3] && state_d[0];
    assign ev_set[`ADCOP_EV_OVF] = enc_rise & powered & (conv_over | conv_under);
    assign ev_set[`ADCOP_EV_SLEEP_EXIT] = wake_done & woke_from_sleep_q;
    assign ev_set[`ADCOP_EV_NAP_EXIT] = wake_done & ~woke_from_sleep_q;

    // all sequential state except the pin synchronisers
    // every output pin and its enable is a flip-flop here, so the pins
    // never glitch on decode paths; the cost is one more mclk of delay.
    always @(posedge mclk) begin
        if (!resetn) begin
            enc_prev_q <= 1'b0;
            state_q <= `ADCOP_ST_RUN;
            wake_cnt_q <= 17'h00000;
            woke_from_sleep_q <= 1'b0;
            stop_cnt_q <= 7'h00;
            relock_cnt_q <= 7'h00;
            sample_word <= {WIDTH{1'b0}};
            sample_word_oe <= {WIDTH{1'b0}};
            overflow_flag <= 1'b0;
            overflow_flag_oe <= 1'b0;
            sample_clock_out <= 1'b0;
            sample_clock_out_oe <= 1'b0;
            stabilizer_on <= 1'b0;
            data_valid <= 1'b0;
            ev_stat_q <= {`ADCOP_EV_WIDTH{1'b0}};
            ev_en_q <= {`ADCOP_EV_WIDTH{1'b0}};
            avs_readdata <= 32'h00000000;
            avs_waitrequest <= 1'b1;
            irq <= 1'b0;
        end else begin
            enc_prev_q <= enc_s;
            state_q <= state_d;
            wake_cnt_q <= wake_cnt_d;
            if (state_q[2]) begin
                woke_from_sleep_q <= 1'b1;
            end else if (state_q[1]) begin
                woke_from_sleep_q <= 1'b0;
            end
            // long stop of the encode clock forces a stabilizer relock
            if (enc_rise || enc_fall) begin
                stop_cnt_q <= 7'h00;
            end else if (stop_cnt_q != STOP_LIM) begin
                stop_cnt_q <= stop_cnt_q + 7'h01;
            end
            if (dcs_want && (stop_cnt_q == STOP_LIM || !stabilizer_on)) begin
                relock_cnt_q <= RELOCK_LIM;
            end else if (enc_rise && !locked) begin
                relock_cnt_q <= relock_cnt_q - 7'h01;
            end
            stabilizer_on <= dcs_want;
            // delayed replica of the encode clock
            // it comes from the same synchronised copy that drives the
            // word update, so word and clock rise on one mclk edge and
            // the receiver has half an encode period on either side.
            sample_clock_out <= enc_s;
            // new word on the rising edge only, stable across the fall
            if (enc_rise && powered) begin
                sample_word <= code_d;
                overflow_flag <= conv_over | conv_under;
            end
            // outputs float when disabled or powered down
            // all enables move together; a partly driven bus would look
            // like a valid word to a receiver that ignores the clock.
            sample_word_oe <= {WIDTH{~dis_s & powered & ~pd_s}};
            overflow_flag_oe <= ~dis_s & powered & ~pd_s;
            sample_clock_out_oe <= ~dis_s & powered & ~pd_s;
            data_valid <= state_q[0] & ~pd_s & (locked | ~dcs_want);
            // sticky status, set wins over clear
            ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
            if (do_wr && avs_address == `ADCOP_REG_ENABLE) begin
                ev_en_q <= avs_writedata[`ADCOP_EV_WIDTH-1:0];
            end
            irq <= |(((ev_stat_q & ~ev_clr) | ev_set) & ev_en_q);
            // one wait cycle per access, then release
            // waitrequest idles high: the cycle with it high is used to
            // latch read data, the cycle with it low is the one where the
            // master completes. a master that holds its request past that
            // cycle simply starts a second access, never a half one.
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
            end else begin
                avs_waitrequest <= 1'b1;
            end
            if ((avs_read || avs_write) && avs_waitrequest) begin
                case (avs_address)
                    `ADCOP_REG_STATUS: avs_readdata <= {29'h0, ev_stat_q};
                    `ADCOP_REG_ENABLE: avs_readdata <= {29'h0, ev_en_q};
                    `ADCOP_REG_STATE: avs_readdata <= {22'h0, data_valid, stabilizer_on, strap_s, state_q, 2'h0};
                    default: avs_readdata <= 32'h00000000;
                endcase
            end else if (do_rd) begin
                avs_readdata <= avs_readdata;
            end
        end
    end

endmodule // adcop_port

// file: tb/adcop_port_checker.sv
/* assertions on adcop_port pins and bus handshake.
   bound to every adcop_port; sees only its ports. */
`timescale 1ns/1ps
module adcop_port_checker #(parameter WIDTH = 12) (
    // clock and reset
    input wire mclk,
    input wire resetn,
    // pins in
    input wire encode_clock_pos,
    input wire [1:0] format_strap,
    input wire output_disable,
    input wire power_down_pin,
    // pins out
    input wire [WIDTH-1:0] sample_word,
    input wire [WIDTH-1:0] sample_word_oe,
    input wire overflow_flag_oe,
    input wire sample_clock_out,
    input wire sample_clock_out_oe,
    input wire stabilizer_on,
    input wire data_valid,
    // bus
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // pins are judged only after they have crossed the synchroniser
    sequence off_held; (output_disable || power_down_pin) [*8]; endsequence
    sequence pd_held; power_down_pin [*8]; endsequence
    wire any_oe = |sample_word_oe || overflow_flag_oe || sample_clock_out_oe;
    a_stab_strap: assert property (
        $stable(format_strap) [*8] |-> stabilizer_on == ^format_strap) else $error("stabilizer wrong");
    a_off_hiz: assert property (
        off_held |-> !any_oe) else $error("outputs driven while off");
    a_pd_invalid: assert property (
        pd_held |-> !data_valid) else $error("valid while powered down");
    a_oe_same: assert property (
        sample_word_oe == {WIDTH{overflow_flag_oe}} && overflow_flag_oe == sample_clock_out_oe)
        else $error("enables differ");
    a_word_on_rise: assert property (
        $past(sample_word_oe[0]) && $changed(sample_word) |-> sample_clock_out) else $error("word moved while clock low");
    a_clk_replica: assert property (
        $rose(encode_clock_pos) && sample_clock_out_oe && !power_down_pin && !output_disable
        |-> ##[2:9] $rose(sample_clock_out)) else $error("sample clock missing");
    a_nap_hold: assert property (
        $fell(power_down_pin) && !output_disable |=> !data_valid [*8]) else $error("valid too soon after nap");
    a_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("bus answer late");
    a_bus_single: assert property (
        !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
endmodule // adcop_port_checker
bind adcop_port adcop_port_checker #(.WIDTH(WIDTH)) chk (.*);

// file: tb/adcop_capture.sv
/* receiver model: latches word and flag as a capture register would.
   assumes the port's pins arrive directly, without board delay. */
`timescale 1ns/1ps
module adcop_capture #(parameter WIDTH = 12) (
    // pins from the port
    input wire sample_clock_out,
    input wire sample_clock_out_oe,
    input wire [WIDTH-1:0] sample_word,
    input wire overflow_flag,
    input wire data_valid,
    // captured values
    output reg [WIDTH-1:0] cap_word,
    output reg cap_flag,
    output reg [15:0] cap_count
);
    initial begin
        cap_word = {WIDTH{1'b0}};
        cap_flag = 1'b0;
        cap_count = 16'h0;
    end
    // falling edge: half a period away from the word change
    always @(negedge sample_clock_out) begin
        if (sample_clock_out_oe) begin
            cap_word <= sample_word;
            cap_flag <= overflow_flag;
            // data after a wake is trusted only once marked valid
            if (data_valid) cap_count <= cap_count + 16'h1;
        end
    end
endmodule // adcop_capture

// file: tb/tb.sv
/* testbench for adcop_port: strap and range rows, overflow interrupt,
   power-down and disable modes. assumes design files compiled first. */
`timescale 1ns/1ps
`include "adcop_map.vh"
module tb;
    logic mclk, resetn, enc, dis, pd, c_over, c_under, a_rd, a_wr;
    logic [1:0] strap;
    logic [11:0] c_val, ev;
    logic [3:0] a_adr;
    logic [31:0] a_wd, q;
    wire [11:0] word, word_oe, cap_word;
    wire flag, flag_oe, sclk, sclk_oe, stab, valid, wreq, irq, cap_flag;
    wire [31:0] rdata;
    wire [15:0] cap_count;
    int err_count, checks_done, cyc, n, i;
    // rows: strap, over, under, raw value
    logic [15:0] rows [7] = '{16'h0123, 16'h4800, 16'h8800, 16'hcfff, 16'h2456, 16'hd456, 16'h8001};
    // wake windows in mclk cycles: nap, disable only, sleep
    int lo [3] = '{790, 0, 70};
    int hi [3] = '{840, 20, 120};

    adcop_port #(.SLEEP_CYCLES(10)) uut (.mclk(mclk), .resetn(resetn), .encode_clock_pos(enc),
        .format_strap(strap), .output_disable(dis), .power_down_pin(pd), .conv_value(c_val),
        .conv_over(c_over), .conv_under(c_under), .sample_word(word), .sample_word_oe(word_oe),
        .overflow_flag(flag), .overflow_flag_oe(flag_oe), .sample_clock_out(sclk),
        .sample_clock_out_oe(sclk_oe), .stabilizer_on(stab), .data_valid(valid), .avs_address(a_adr),
        .avs_read(a_rd), .avs_write(a_wr), .avs_writedata(a_wd), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .irq(irq));
    adcop_capture cap (.sample_clock_out(sclk), .sample_clock_out_oe(sclk_oe), .sample_word(word),
        .overflow_flag(flag), .data_valid(valid), .cap_word(cap_word), .cap_flag(cap_flag),
        .cap_count(cap_count));

    initial begin
        mclk = 0;
        forever #20 mclk = ~mclk;
    end
    // encode clock runs free, phase unrelated to mclk
    initial begin
        enc = 0;
        #7;
        forever #160 enc = ~enc;
    end
    // hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one avalon access; held until waitrequest is seen low
    task bus(input logic w, input logic [3:0] adr, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        a_adr <= adr;
        a_wd <= d;
        a_wr <= w;
        a_rd <= !w;
        // look between edges: the value seen here is what the next edge samples
        do begin
            @(negedge mclk);
            k++;
        end while (wreq !== 1'b0 && k < 50);
        if (k >= 50) begin
            err_count++;
            finish_test();
        end
        q = rdata;
        @(posedge mclk);
        a_rd <= 0;
        a_wr <= 0;
    endtask
    task finish_test;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        {resetn, dis, pd, strap, c_val, c_over, c_under} = 0;
        {a_adr, a_rd, a_wr, a_wd, err_count, checks_done, cyc} = 0;
        repeat (4) @(posedge mclk);
        resetn <= 1;
        // enable resets to zero, holes read zero, then arm overflow
        bus(0, `ADCOP_REG_ENABLE, 0);
        check(q, 0);
        bus(0, 4'h2, 0);
        check(q, 0);
        bus(1, `ADCOP_REG_ENABLE, 1);
        $display("registers done");
        for (i = 0; i < 7; i++) begin
            {strap, c_over, c_under, c_val} <= rows[i];
            repeat (48) @(posedge mclk);
            ev = rows[i][13] ? 12'hfff : rows[i][12] ? 12'h000 : rows[i][11:0];
            check(cap_word, ev ^ {rows[i][15], 11'h0});
            check(cap_flag, rows[i][13] | rows[i][12]);
            check(stab, ^rows[i][15:14]);
        end
        $display("rows done");
        // overflow rows left the sticky bit set: raise, mask, clear
        check(irq, 1);
        bus(0, `ADCOP_REG_STATUS, 0);
        check(q[0], 1);
        bus(1, `ADCOP_REG_ENABLE, 0);
        repeat (2) @(posedge mclk);
        check(irq, 0);
        bus(1, `ADCOP_REG_ENABLE, 1);
        repeat (2) @(posedge mclk);
        check(irq, 1);
        bus(1, `ADCOP_REG_CLEAR, 1);
        repeat (2) @(posedge mclk);
        check(irq, 0);
        $display("interrupt done");
        // stabilizer off so wake time is not mixed with a relock
        strap <= 2'h0;
        for (i = 1; i < 4; i++) begin
            {dis, pd} <= i[1:0];
            repeat (16) @(posedge mclk);
            check({word_oe, flag_oe, sclk_oe}, 0);
            if (pd) check(valid, 0);
            {dis, pd} <= 2'h0;
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (!(valid === 1'b1 && sclk_oe === 1'b1) && n < 2000);
            checks_done++;
            if (n < lo[i-1] || n > hi[i-1]) begin
                err_count++;
                $display("[ERR] t=%0t got %h exp %h", $time, n, lo[i-1]);
            end
            $display("mode %0d done", i);
        end
        // nap and sleep exits both flagged; state shows running, valid
        bus(0, `ADCOP_REG_STATUS, 0);
        check(q, 32'h00000006);
        bus(0, `ADCOP_REG_STATE, 0);
        check(q, 32'h00000204);
        // reset in mid-run: pins float, bus idle, registers cleared
        resetn <= 0;
        repeat (4) @(posedge mclk);
        check({word_oe, flag_oe, sclk_oe, valid, irq, wreq}, 1);
        resetn <= 1;
        bus(0, `ADCOP_REG_ENABLE, 0);
        check(q, 0);
        bus(0, `ADCOP_REG_STATUS, 0);
        check(q, 0);
        $display("reset done");
        finish_test();
    end
endmodule // tb
